// >>> core/psr_core.sv
`timescale 1ns/100ps
`include "psr_defines.svh"
// Function
// RL1: regset enable gates same-set external interrupts
// RL2: without controller, regset enable reads one
// RL3: nmi flag read-only, set on nmi
// RL4: previous regset copy rules with MMU
// RL5: regset copy after state save
// RL6: regset fields sized to set count
// RL7: software writes valid previous regset only
// RL8: current regset read-only, zero on exceptions
// RL9: level must exceed threshold
// RL10: external handler flag set on interrupt
// RL11: exception handler set on every exception
// RL12: miss class from exception handler bit
// RL13: no MMU keeps handler, user zero
// RL14: user bit selects privilege level
// RL15: global enable gates maskable interrupts
// RL16: bits 31 to 24 reserved
// RL17: absent fields read as zero
// RL18: control access only in supervisor
// RL19: software writes zeros to reserved bits
// RL20: software never sets handler and user
// RL21: entry updates take effect together
module psr_core #(
  parameter bit HAS_IRQ_CTRL = 1'b1,
  parameter bit HAS_MMU = 1'b1,
  parameter int NUM_SETS = 8,
  parameter int RS_W = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ctl_wr,
  input wire logic ctl_rd,
  input wire logic [4:0] ctl_index,
  input wire logic [31:0] ctl_wdata,
  output logic [31:0] ctl_rdata,
  output logic ctl_denied,
  input wire psr_pkg::psr_event_t entry_event,
  input wire logic irq_valid,
  input wire logic irq_nmi,
  input wire logic [`PSR_LVL_W-1:0] irq_level,
  input wire logic [RS_W-1:0] irq_set,
  output logic irq_take,
  output logic [31:0] saved_state,
  input wire logic tlb_miss,
  output logic tlb_double_miss,
  output logic user_mode,
  output logic [RS_W-1:0] current_regset
);
  import psr_pkg::*;

  // shadow sets need the controller port; otherwise only set 0 exists
  localparam bit SHADOW = HAS_IRQ_CTRL && (NUM_SETS > 1);

  logic gie_ff, nxt_gie;
  logic user_ff, nxt_user;
  logic exc_hnd_ff, nxt_exc_hnd;
  logic ext_hnd_ff, nxt_ext_hnd;
  logic [`PSR_LVL_W-1:0] lvl_thr_ff, nxt_lvl_thr;
  logic [RS_W-1:0] cur_set_ff, nxt_cur_set;
  logic [RS_W-1:0] prev_set_ff, nxt_prev_set;
  logic nmi_ff, nxt_nmi;
  logic rie_ff, nxt_rie;
  logic [31:0] saved_ff, nxt_saved;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] state_word;
  logic rie_eff;
  logic gate_take;
  logic acc_ok;
  logic wr_ok;
  logic rd_ok;

  // state register selected and caller in supervisor mode
  function automatic logic state_access(input logic [4:0] index, input logic user);
    return (index == `PSR_CTL_INDEX) && !user; // RL18
  endfunction

  // fields passed in explicitly so every caller re-evaluates on any field change
  function automatic logic [31:0] pack_state(
    input logic gie,
    input logic user,
    input logic exc_hnd,
    input logic ext_hnd,
    input logic [`PSR_LVL_W-1:0] lvl_thr,
    input logic [RS_W-1:0] cur_set,
    input logic [RS_W-1:0] prev_set,
    input logic nmi,
    input logic rie
  );
    logic [31:0] w;
    w = 32'h0000_0000; // RL16 RL17
    w[`PSR_BIT_GIE] = gie;
    w[`PSR_BIT_U] = user;
    w[`PSR_BIT_EXC_HND] = exc_hnd;
    w[`PSR_BIT_EXT_HND] = ext_hnd;
    w[`PSR_LVL_LSB +: `PSR_LVL_W] = lvl_thr;
    w[`PSR_CUR_SET_LSB +: RS_W] = cur_set; // RL6
    w[`PSR_PREV_SET_LSB +: RS_W] = prev_set; // RL6
    w[`PSR_BIT_NMI] = nmi;
    w[`PSR_BIT_RIE] = rie;
    return w;
  endfunction

  assign rie_eff = SHADOW ? rie_ff : 1'b1; // RL2

  always_comb begin
    state_word = pack_state(gie_ff, user_ff, exc_hnd_ff, ext_hnd_ff, lvl_thr_ff, cur_set_ff, prev_set_ff, nmi_ff,
      rie_eff);
  end

  psr_irq_gate #(.RS_W(RS_W), .LVL_W(`PSR_LVL_W)) psr_irq_gate_inst (
    .gie(gie_ff),
    .rie(rie_eff),
    .level_thr(lvl_thr_ff),
    .cur_set(cur_set_ff),
    .req_valid(irq_valid && HAS_IRQ_CTRL),
    .req_nmi(irq_nmi),
    .req_level(irq_level),
    .req_set(irq_set),
    .take(gate_take)
  );
  assign irq_take = gate_take;

  assign acc_ok = state_access(ctl_index, user_ff);
  assign wr_ok = ctl_wr && acc_ok; // RL18
  assign rd_ok = ctl_rd && acc_ok; // RL18
  // a user-mode access is flagged at once and leaves the state untouched
  assign ctl_denied = (ctl_wr || ctl_rd) && user_ff; // RL18

  always_comb begin
    nxt_gie = gie_ff;
    nxt_user = user_ff;
    nxt_exc_hnd = exc_hnd_ff;
    nxt_ext_hnd = ext_hnd_ff;
    nxt_lvl_thr = lvl_thr_ff;
    nxt_cur_set = cur_set_ff;
    nxt_prev_set = prev_set_ff;
    nxt_nmi = nmi_ff;
    nxt_rie = rie_ff;
    nxt_saved = saved_ff;
    // read data stands for one cycle and is zero otherwise
    nxt_rdata = rd_ok ? state_word : 32'h0000_0000;
    // entry has priority over a software write in the same cycle
    if (entry_event != PSR_EV_NONE) begin
      nxt_saved = state_word; // RL5
      if (!HAS_MMU || entry_event == PSR_EV_BRK || exc_hnd_ff == 1'b0) begin
        nxt_prev_set = cur_set_ff; // RL4 RL5
      end
      nxt_user = 1'b0;
      nxt_gie = 1'b0;
      if (HAS_MMU) begin
        nxt_exc_hnd = 1'b1; // RL11
      end
      if (entry_event == PSR_EV_IRQ && HAS_IRQ_CTRL) begin
        nxt_ext_hnd = 1'b1; // RL10
        nxt_nmi = irq_nmi; // RL3
        nxt_cur_set = irq_set;
        nxt_lvl_thr = irq_level;
      end else begin
        nxt_cur_set = '0; // RL8
      end
    end else if (wr_ok) begin
      nxt_gie = ctl_wdata[`PSR_BIT_GIE]; // RL15
      nxt_user = HAS_MMU && ctl_wdata[`PSR_BIT_U]; // RL14 RL13
      nxt_exc_hnd = HAS_MMU && ctl_wdata[`PSR_BIT_EXC_HND]; // RL11 RL13
      nxt_ext_hnd = HAS_IRQ_CTRL && ctl_wdata[`PSR_BIT_EXT_HND];
      nxt_lvl_thr = HAS_IRQ_CTRL ? ctl_wdata[`PSR_LVL_LSB +: `PSR_LVL_W] : '0;
      nxt_prev_set = SHADOW ? ctl_wdata[`PSR_PREV_SET_LSB +: RS_W] : '0; // RL7
      nxt_rie = ctl_wdata[`PSR_BIT_RIE];
    end
    if (!SHADOW) begin
      nxt_cur_set = '0; // RL17
      nxt_prev_set = '0;
    end
  end

  // all entry updates land on one edge
  always_ff @(posedge clk or posedge reset) begin // RL21
    if (reset) begin
      gie_ff <= 1'b0;
      user_ff <= 1'b0;
      exc_hnd_ff <= 1'b0;
      ext_hnd_ff <= 1'b0;
      lvl_thr_ff <= '0;
      cur_set_ff <= '0;
      prev_set_ff <= '0;
      nmi_ff <= 1'b0;
      rie_ff <= `PSR_RST_RIE;
      saved_ff <= 32'h0000_0000;
      rdata_ff <= 32'h0000_0000;
    end else begin
      gie_ff <= nxt_gie;
      user_ff <= nxt_user;
      exc_hnd_ff <= nxt_exc_hnd;
      ext_hnd_ff <= nxt_ext_hnd;
      lvl_thr_ff <= nxt_lvl_thr;
      cur_set_ff <= nxt_cur_set;
      prev_set_ff <= nxt_prev_set;
      nmi_ff <= nxt_nmi;
      rie_ff <= nxt_rie;
      saved_ff <= nxt_saved;
      rdata_ff <= nxt_rdata;
    end
  end

  assign ctl_rdata = rdata_ff;
  assign saved_state = saved_ff;
  assign tlb_double_miss = tlb_miss && exc_hnd_ff; // RL12
  assign user_mode = user_ff; // RL14
  assign current_regset = cur_set_ff;

  AST_RSV_ZERO: assert property (@(posedge clk) disable iff (reset) // RL16
    state_word[31:`PSR_RSV_LSB] == 8'h00) else $error("reserved bits nonzero");
  AST_EH_SET: assert property (@(posedge clk) disable iff (reset) // RL11
    (entry_event != PSR_EV_NONE && HAS_MMU) |=> exc_hnd_ff) else $error("handler bit not set on entry");
  AST_CRS_ZERO: assert property (@(posedge clk) disable iff (reset) // RL8
    (entry_event inside {PSR_EV_EXC, PSR_EV_BRK}) |=> cur_set_ff == '0) else $error("current set not cleared");
  AST_PRS_COPY: assert property (@(posedge clk) disable iff (reset) // RL4
    (entry_event == PSR_EV_BRK) |=> prev_set_ff == (SHADOW ? $past(cur_set_ff) : '0))
    else $error("previous set not copied");
  AST_PRS_KEEP: assert property (@(posedge clk) disable iff (reset) // RL4
    (HAS_MMU && exc_hnd_ff && entry_event inside {PSR_EV_EXC, PSR_EV_IRQ}) |=> $stable(prev_set_ff))
    else $error("previous set copied while handler active");
  AST_SAVE: assert property (@(posedge clk) disable iff (reset) // RL5
    (entry_event != PSR_EV_NONE) |=> saved_ff == $past(state_word)) else $error("state not saved");
  AST_IH_SET: assert property (@(posedge clk) disable iff (reset) // RL10
    (entry_event == PSR_EV_IRQ && HAS_IRQ_CTRL) |=> ext_hnd_ff) else $error("external handler flag not set");
  AST_NMI_SET: assert property (@(posedge clk) disable iff (reset) // RL3
    (entry_event == PSR_EV_IRQ && HAS_IRQ_CTRL && irq_nmi) |=> state_word[`PSR_BIT_NMI]) else $error("nmi not set");
  AST_LEVEL: assert property (@(posedge clk) disable iff (reset) // RL9
    (irq_take && !irq_nmi) |-> (irq_level > lvl_thr_ff && gie_ff)) else $error("level gate broken");
  AST_RIE: assert property (@(posedge clk) disable iff (reset) // RL1
    (irq_take && irq_set == cur_set_ff) |-> rie_eff) else $error("same set taken");
  AST_NO_MMU: assert property (@(posedge clk) disable iff (reset) // RL13
    !HAS_MMU |-> (!exc_hnd_ff && !user_ff)) else $error("handler or user set without mmu");
  AST_DENY: assert property (@(posedge clk) disable iff (reset) // RL18
    (user_ff && ctl_wr) |=> $stable(gie_ff) || entry_event != PSR_EV_NONE || $past(entry_event) != PSR_EV_NONE)
    else $error("user write took effect");
  AST_RD_DENY: assert property (@(posedge clk) disable iff (reset) // RL18
    (ctl_rd && user_ff) |=> ctl_rdata == 32'h0000_0000) else $error("user read returned data");
  COV_IRQ: cover property (@(posedge clk) disable iff (reset) entry_event == PSR_EV_IRQ);
  COV_BRK: cover property (@(posedge clk) disable iff (reset) entry_event == PSR_EV_BRK);
  COV_WR: cover property (@(posedge clk) disable iff (reset) wr_ok);
  COV_DBL: cover property (@(posedge clk) disable iff (reset) tlb_double_miss);
  COV_NMI: cover property (@(posedge clk) disable iff (reset) entry_event == PSR_EV_IRQ && irq_nmi);
endmodule

// >>> core/psr_defines.svh
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH
`define PSR_BIT_RIE 23
`define PSR_BIT_NMI 22
`define PSR_PREV_SET_LSB 16
`define PSR_CUR_SET_LSB 10
`define PSR_LVL_LSB 4
`define PSR_LVL_W 6
`define PSR_BIT_EXT_HND 3
`define PSR_BIT_EXC_HND 2
`define PSR_BIT_U 1
`define PSR_BIT_GIE 0
`define PSR_RSV_LSB 24
`define PSR_RST_RIE 1'b1
`define PSR_CTL_INDEX 5'h0
`endif

// >>> core/psr_irq_gate.sv
`timescale 1ns/100ps
`include "psr_defines.svh"
// decides whether an external interrupt request may be taken now
module psr_irq_gate #(
  parameter int RS_W = 3,
  parameter int LVL_W = 6
) (
  input wire logic gie,
  input wire logic rie,
  input wire logic [LVL_W-1:0] level_thr,
  input wire logic [RS_W-1:0] cur_set,
  input wire logic req_valid,
  input wire logic req_nmi,
  input wire logic [LVL_W-1:0] req_level,
  input wire logic [RS_W-1:0] req_set,
  output logic take
);
  logic same_set_ok;
  logic maskable_ok;
  always_comb begin
    same_set_ok = rie || (req_set != cur_set); // RL1
    maskable_ok = gie && (req_level > level_thr); // RL9 RL15
    take = req_valid && same_set_ok && (req_nmi || maskable_ok);
  end
endmodule

// >>> core/psr_pkg.sv
package psr_pkg;
  typedef enum logic [1:0] {
    PSR_EV_NONE,
    PSR_EV_EXC,
    PSR_EV_BRK,
    PSR_EV_IRQ
  } psr_event_t;
endpackage

// >>> sim/psr_core_test.sv
`timescale 1ns/100ps
module psr_core_test;
  import psr_pkg::*;
  logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, req = 1'b0, nmi = 1'b0, miss = 1'b0;
  logic [31:0] wdata = '0, rdata, saved;
  logic [5:0] lvl = '0, irq_level;
  logic [2:0] set = '0, irq_set, cur_set;
  logic [4:0] idx = 5'h0;
  logic denied, take, dmiss, umode, irq_valid, irq_nmi;
  psr_event_t ev = PSR_EV_NONE;
  int fails = 0, checked = 0;
  psr_core psr_core_inst (.clk(clk), .reset(reset), .ctl_wr(wr), .ctl_rd(rd), .ctl_index(idx),
    .ctl_wdata(wdata), .ctl_rdata(rdata), .ctl_denied(denied), .entry_event(ev), .irq_valid(irq_valid),
    .irq_nmi(irq_nmi), .irq_level(irq_level), .irq_set(irq_set), .irq_take(take), .saved_state(saved),
    .tlb_miss(miss), .tlb_double_miss(dmiss), .user_mode(umode), .current_regset(cur_set));
  psr_irq_ctrl_model #(.RS_W(3)) psr_irq_ctrl_model_inst (.clk(clk), .req(req), .nmi(nmi), .level(lvl), .set(set),
    .irq_valid(irq_valid), .irq_nmi(irq_nmi), .irq_level(irq_level), .irq_set(irq_set));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_word(input logic [31:0] d);
    @(negedge clk) wr = 1'b1;
    wdata = d;
    @(negedge clk) wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [31:0] exp);
    @(negedge clk) rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    check("state word", rdata, exp);
  endtask
  task automatic enter(input psr_event_t e);
    @(negedge clk) ev = e;
    @(negedge clk) ev = PSR_EV_NONE;
  endtask
  task automatic ask(input logic [5:0] l, input logic [2:0] s, input logic exp);
    @(negedge clk) req = 1'b1;
    lvl = l;
    set = s;
    #1 check("irq take", {31'h0, take}, {31'h0, exp});
  endtask
  task automatic t_reset();
    rd_chk(32'h0080_0000);
    check("user mode", {31'h0, umode}, 32'h0);
    check("regset", {29'h0, cur_set}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_gate();
    idx = 5'h1;
    wr_word(32'h0080_0031);
    rd_chk(32'h0);
    idx = 5'h0;
    rd_chk(32'h0080_0000);
    wr_word(32'h0080_0030);
    ask(6'h05, 3'h1, 1'b0);
    wr_word(32'h0080_0031);
    ask(6'h03, 3'h1, 1'b0);
    ask(6'h04, 3'h0, 1'b1);
    wr_word(32'h0000_0031);
    ask(6'h04, 3'h0, 1'b0);
    wr_word(32'h0080_0031);
    $display("gate test done");
  endtask
  task automatic t_entry();
    ask(6'h04, 3'h2, 1'b1);
    enter(PSR_EV_IRQ);
    check("saved", saved, 32'h0080_0031);
    rd_chk(32'h0080_084C);
    check("regset", {29'h0, cur_set}, 32'h2);
    @(negedge clk) miss = 1'b1;
    #1 check("double miss", {31'h0, dmiss}, 32'h1);
    enter(PSR_EV_EXC);
    rd_chk(32'h0080_004C);
    wr_word(32'h0080_0000);
    #1 check("double miss", {31'h0, dmiss}, 32'h0);
    miss = 1'b0;
    $display("entry test done");
  endtask
  task automatic t_nmi();
    nmi = 1'b1;
    ask(6'h01, 3'h1, 1'b1);
    enter(PSR_EV_IRQ);
    req = 1'b0;
    rd_chk(32'h00C0_041C);
    wr_word(32'h0082_0000);
    rd_chk(32'h00C2_0400);
    $display("nmi test done");
  endtask
  task automatic t_user();
    wr_word(32'h0080_0002);
    check("user mode", {31'h0, umode}, 32'h1);
    rd_chk(32'h0);
    @(negedge clk) wr = 1'b1;
    wdata = 32'h0080_0001;
    #1 check("denied", {31'h0, denied}, 32'h1);
    @(negedge clk) wr = 1'b0;
    check("user mode", {31'h0, umode}, 32'h1);
    enter(PSR_EV_EXC);
    check("user mode", {31'h0, umode}, 32'h0);
    rd_chk(32'h00C1_0004);
    $display("user test done");
  endtask
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_gate();
    t_entry();
    t_nmi();
    t_user();
    @(negedge clk) reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_reset();
    finish_test();
  end
endmodule

// >>> sim/psr_eic_model.sv
`timescale 1ns/100ps
// interrupt controller stand-in; idle fields toggle so no stale level is trusted
module psr_irq_ctrl_model #(
  parameter int RS_W = 3
) (
  clk,
  req,
  nmi,
  level,
  set,
  irq_valid,
  irq_nmi,
  irq_level,
  irq_set
);
  input wire logic clk;
  input wire logic req;
  input wire logic nmi;
  input wire logic [5:0] level;
  input wire logic [RS_W-1:0] set;
  output logic irq_valid;
  output logic irq_nmi;
  output logic [5:0] irq_level;
  output logic [RS_W-1:0] irq_set;
  logic idle_ff = 1'b0;
  always @(negedge clk) idle_ff <= ~idle_ff;
  assign irq_valid = req;
  assign irq_nmi = req ? nmi : idle_ff;
  assign irq_level = req ? level : {6{idle_ff}};
  assign irq_set = req ? set : {RS_W{idle_ff}};
endmodule
